/* File: capregs_pkg.sv */
package capregs_pkg;
    // configuration-space byte offsets of this slice
    localparam logic [11:0] L1SS_HDR_OFF = 12'h240;
    localparam logic [11:0] L1SS_CAP_OFF = 12'h244;
    localparam logic [11:0] L1SS_CTL1_OFF = 12'h248;
    localparam logic [11:0] L1SS_CTL2_OFF = 12'h24c;
    localparam logic [11:0] DPC_HDR_OFF = 12'h250;
    localparam logic [11:0] DPC_CAP_OFF = 12'h254;

    // extended capability header fields
    localparam logic [15:0] L1SS_CAP_ID = 16'h001e;
    localparam logic [15:0] DPC_CAP_ID = 16'h001d;
    localparam logic [3:0] CAP_VERSION = 4'h1;
    localparam logic [11:0] PTR_UPSTREAM = 12'h260;
    localparam logic [11:0] PTR_DOWNSTREAM = 12'h250;
    localparam logic [11:0] PTR_END = 12'h000;

    // bit positions in the capability register; bits 1 and 3 are shared with control 1
    localparam int PM_L11_BIT = 1;
    localparam int ASPM_L11_BIT = 3;
    localparam int L1SS_SUP_BIT = 4;

    // reset values and fixed read values
    localparam logic PM_L11_SUP_RST = 1'h1;
    localparam logic ASPM_L11_SUP_RST = 1'h0;
    localparam logic L1SS_SUP_RST = 1'h1;
    localparam logic ENABLE_RST = 1'h0;
    localparam logic [4:0] DPC_MSG_NUM = 5'h01;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

/* File: l1ss_dpc_regs.sv */
// Operation
// - L1 substates header bits 15:0 read 001Eh, fixed.
// - each header in this slice reports version 1h in bits 19:16.
// - L1 substates next pointer is 260h upstream, 250h downstream.
// - PCI-PM L1.1 supported bit reads 1 at reset; only EEPROM changes it.
// - ASPM L1.1 supported bit reads 0 at reset; sideband or EEPROM change it.
// - L1 substates supported bit reads 1 at reset; EEPROM changes it.
// - control 1 bit 1 is writable PCI-PM L1.1 enable, resets to 0.
// - control 1 bit 3 is writable ASPM L1.1 enable, resets to 0.
// - downstream ports expose a containment header with ID 001Dh.
// - containment header next pointer reads 000h, ending the list.
// - containment capability bits 4:0 read message number 00001b.
`timescale 1ns/1ps
module l1ss_dpc_regs (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // port role strap, high for a downstream port
    input wire logic downstream_strap,
    // configuration access
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire logic [11:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic cfg_hit,
    output logic [31:0] cfg_rdata,
    // eeprom autoload of capability defaults
    input wire logic eeprom_load,
    input wire logic eeprom_pm_l11_sup,
    input wire logic eeprom_aspm_l11_sup,
    input wire logic eeprom_l1ss_sup,
    // smbus or i2c sideband override
    input wire logic sideband_load,
    input wire logic sideband_aspm_l11_sup,
    // enables toward the link power logic
    output logic pm_l11_enable,
    output logic aspm_l11_enable
);
    logic [2:0] strap_sync_q;
    logic strap_done_q;
    logic downstream_q;
    logic pm_l11_sup_q;
    logic aspm_l11_sup_q;
    logic l1ss_sup_q;
    logic pm_l11_en_q;
    logic aspm_l11_en_q;
    logic cfg_ack_q;
    logic cfg_hit_q;
    logic [31:0] cfg_rdata_q;
    logic [31:0] rd_d;
    logic hit_d;
    logic take;

    assign take = clk_en && cfg_req;

    function automatic logic [31:0] cap_header(
        input logic [15:0] id,
        input logic [11:0] ptr
    );
        cap_header = {ptr, capregs_pkg::CAP_VERSION, id};
    endfunction

    function automatic logic [31:0] bit_word(
        input logic pm_bit,
        input logic aspm_bit
    );
        logic [31:0] w;
        w = capregs_pkg::ZERO_WORD;
        w[capregs_pkg::PM_L11_BIT] = pm_bit;
        w[capregs_pkg::ASPM_L11_BIT] = aspm_bit;
        bit_word = w;
    endfunction

    // the strap pin is not timed to the core clock; the chain runs under
    // reset too, so it has settled by the time reset lets go
    always_ff @(posedge clock) begin
        if (clk_en) begin
            strap_sync_q <= {strap_sync_q[1:0], downstream_strap};
        end
    end

    // the strap is caught once after reset release, never under reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_q <= 1'b0;
            downstream_q <= 1'b0;
        end else if (clk_en && !strap_done_q &&
                     strap_sync_q[2] == strap_sync_q[1]) begin
            strap_done_q <= 1'b1;
            downstream_q <= strap_sync_q[2];
        end
    end

    // capability defaults; eeprom wins over sideband in the same cycle
    // because autoload is the later, board-level configuration
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pm_l11_sup_q <= capregs_pkg::PM_L11_SUP_RST;
            aspm_l11_sup_q <= capregs_pkg::ASPM_L11_SUP_RST;
            l1ss_sup_q <= capregs_pkg::L1SS_SUP_RST;
        end else if (clk_en) begin
            if (eeprom_load) begin
                pm_l11_sup_q <= eeprom_pm_l11_sup;
                aspm_l11_sup_q <= eeprom_aspm_l11_sup;
                l1ss_sup_q <= eeprom_l1ss_sup;
            end else if (sideband_load) begin
                aspm_l11_sup_q <= sideband_aspm_l11_sup;
            end
        end
    end

    // control 1: only bits 1 and 3 hold state, the rest is dropped
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pm_l11_en_q <= capregs_pkg::ENABLE_RST;
            aspm_l11_en_q <= capregs_pkg::ENABLE_RST;
        end else if (take && cfg_write && cfg_be[0] &&
                     cfg_addr == capregs_pkg::L1SS_CTL1_OFF) begin
            pm_l11_en_q <= cfg_wdata[capregs_pkg::PM_L11_BIT];
            aspm_l11_en_q <= cfg_wdata[capregs_pkg::ASPM_L11_BIT];
        end
    end

    // read decode; containment words vanish on the upstream port
    always_comb begin
        rd_d = capregs_pkg::ZERO_WORD;
        hit_d = 1'b1;
        if (cfg_addr == capregs_pkg::L1SS_HDR_OFF) begin
            rd_d = cap_header(capregs_pkg::L1SS_CAP_ID,
                downstream_q ? capregs_pkg::PTR_DOWNSTREAM
                             : capregs_pkg::PTR_UPSTREAM);
        end else if (cfg_addr == capregs_pkg::L1SS_CAP_OFF) begin
            rd_d = bit_word(pm_l11_sup_q, aspm_l11_sup_q);
            rd_d[capregs_pkg::L1SS_SUP_BIT] = l1ss_sup_q;
        end else if (cfg_addr == capregs_pkg::L1SS_CTL1_OFF) begin
            rd_d = bit_word(pm_l11_en_q, aspm_l11_en_q);
        end else if (cfg_addr == capregs_pkg::L1SS_CTL2_OFF) begin
            rd_d = capregs_pkg::ZERO_WORD;
        end else if (downstream_q &&
                     cfg_addr == capregs_pkg::DPC_HDR_OFF) begin
            rd_d = cap_header(capregs_pkg::DPC_CAP_ID,
                capregs_pkg::PTR_END);
        end else if (downstream_q &&
                     cfg_addr == capregs_pkg::DPC_CAP_OFF) begin
            rd_d = 32'(capregs_pkg::DPC_MSG_NUM);
        end else begin
            hit_d = 1'b0;
        end
    end

    // one-cycle answer; write answers return zero data
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ack_q <= 1'b0;
            cfg_hit_q <= 1'b0;
            cfg_rdata_q <= capregs_pkg::ZERO_WORD;
        end else if (clk_en) begin
            cfg_ack_q <= cfg_req;
            if (cfg_req) begin
                cfg_hit_q <= hit_d;
                cfg_rdata_q <= cfg_write ? capregs_pkg::ZERO_WORD : rd_d;
            end
        end
    end

    assign cfg_ack = cfg_ack_q;
    assign cfg_hit = cfg_hit_q;
    assign cfg_rdata = cfg_rdata_q;
    assign pm_l11_enable = pm_l11_en_q;
    assign aspm_l11_enable = aspm_l11_en_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_read(logic [11:0] off);
        clk_en && cfg_req && !cfg_write && cfg_addr == off;
    endsequence

    sequence s_write_ctl1;
        clk_en && cfg_req && cfg_write && cfg_be[0] &&
            cfg_addr == capregs_pkg::L1SS_CTL1_OFF;
    endsequence

    a_l1ss_hdr_id: assert property (
        s_read(capregs_pkg::L1SS_HDR_OFF) |=> cfg_ack &&
            cfg_rdata[15:0] == capregs_pkg::L1SS_CAP_ID)
        else $error("l1 substates header id wrong");

    a_hdr_version: assert property (
        (s_read(capregs_pkg::L1SS_HDR_OFF) or
         (s_read(capregs_pkg::DPC_HDR_OFF) and downstream_q)) |=>
            cfg_rdata[19:16] == capregs_pkg::CAP_VERSION)
        else $error("capability version wrong");

    a_next_pointer: assert property (
        s_read(capregs_pkg::L1SS_HDR_OFF) |=> cfg_rdata[31:20] ==
            ($past(downstream_q) ? capregs_pkg::PTR_DOWNSTREAM
                                 : capregs_pkg::PTR_UPSTREAM))
        else $error("next capability pointer wrong");

    a_pm_sup_hold: assert property (
        clk_en && !eeprom_load |=> $stable(pm_l11_sup_q))
        else $error("pm l1.1 supported changed without autoload");

    a_aspm_sup_hold: assert property (
        clk_en && !eeprom_load && !sideband_load |=> $stable(aspm_l11_sup_q))
        else $error("aspm l1.1 supported changed without load");

    a_l1ss_sup_load: assert property (
        clk_en && eeprom_load |=> l1ss_sup_q == $past(eeprom_l1ss_sup))
        else $error("l1 substates supported not autoloaded");

    a_ctl_write_read: assert property (
        s_write_ctl1 ##1 s_read(capregs_pkg::L1SS_CTL1_OFF) |=>
            cfg_rdata[capregs_pkg::PM_L11_BIT] ==
                $past(cfg_wdata[capregs_pkg::PM_L11_BIT], 2) &&
            cfg_rdata[capregs_pkg::ASPM_L11_BIT] ==
                $past(cfg_wdata[capregs_pkg::ASPM_L11_BIT], 2))
        else $error("control 1 enable write not read back");

    a_dpc_hdr: assert property (
        s_read(capregs_pkg::DPC_HDR_OFF) |=> cfg_hit == $past(downstream_q)
            && cfg_rdata == ($past(downstream_q) ? {capregs_pkg::PTR_END,
            capregs_pkg::CAP_VERSION, capregs_pkg::DPC_CAP_ID}
            : capregs_pkg::ZERO_WORD))
        else $error("containment header wrong");

    a_dpc_msg_num: assert property (
        s_read(capregs_pkg::DPC_CAP_OFF) ##0 downstream_q |=>
            cfg_rdata[4:0] == capregs_pkg::DPC_MSG_NUM)
        else $error("containment message number wrong");

    a_rsvd_zero: assert property (
        s_read(capregs_pkg::L1SS_CTL2_OFF) or
        s_read(capregs_pkg::L1SS_CTL1_OFF) |=> cfg_rdata[31:4] == 28'h0 &&
            cfg_rdata[0] == 1'b0 && cfg_rdata[2] == 1'b0)
        else $error("reserved bits not zero");

    a_cap_rsvd_zero: assert property (
        s_read(capregs_pkg::L1SS_CAP_OFF) |=> cfg_rdata[31:5] == 27'h0 &&
            cfg_rdata[2] == 1'b0 && cfg_rdata[0] == 1'b0)
        else $error("capability reserved bits not zero");

    a_ctl2_zero: assert property (
        s_read(capregs_pkg::L1SS_CTL2_OFF) |=>
            cfg_rdata == capregs_pkg::ZERO_WORD)
        else $error("control 2 not zero");
endmodule

/* File: l1ss_dpc_regs_tb.sv */
`timescale 1ns/1ps
module l1ss_dpc_regs_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic downstream_strap = 1'b0;
    logic cfg_req = 1'b0;
    logic cfg_write = 1'b0;
    logic [11:0] cfg_addr = 12'h000;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic eeprom_load = 1'b0;
    logic [2:0] ee = 3'h0;
    logic sideband_load = 1'b0;
    logic sb_aspm = 1'b0;
    logic cfg_ack;
    logic cfg_hit;
    logic [31:0] cfg_rdata;
    logic pm_en;
    logic aspm_en;
    logic [32:0] exp_q[$];
    string name_q[$];
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] cap_w;
    logic [31:0] d;
    always #2.5 clock = ~clock;
    l1ss_dpc_regs dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
        .downstream_strap(downstream_strap), .cfg_req(cfg_req),
        .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_hit(cfg_hit),
        .cfg_rdata(cfg_rdata), .eeprom_load(eeprom_load),
        .eeprom_pm_l11_sup(ee[0]), .eeprom_aspm_l11_sup(ee[1]),
        .eeprom_l1ss_sup(ee[2]), .sideband_load(sideband_load),
        .sideband_aspm_l11_sup(sb_aspm), .pm_l11_enable(pm_en),
        .aspm_l11_enable(aspm_en));
    task automatic chk(input string n, input logic [32:0] e,
                       input logic [32:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ceiling is about twenty times the length of the sequence below
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            complete_run();
        end
    end
    // ack stands one cycle, so the middle of that cycle is where it is read
    always @(negedge clock) begin
        if (cfg_ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("cfg_ack", 33'h0, 33'h1);
            end else begin
                chk(name_q.pop_front(), exp_q.pop_front(), {cfg_hit, cfg_rdata});
            end
        end
    end
    task automatic step();
        @(posedge clock);
        #1;
        cfg_req = 1'b0;
        eeprom_load = 1'b0;
        sideband_load = 1'b0;
    endtask
    task automatic tend(input string n);
        repeat (3) step();
        chk("answers outstanding", 33'h0, 33'(exp_q.size()));
        $display("test %s finished", n);
    endtask
    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, input logic [3:0] be,
                       input logic [32:0] e, input string n);
        @(posedge clock);
        #1;
        cfg_req = 1'b1;
        cfg_write = w;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = wd;
        exp_q.push_back(e);
        name_q.push_back(n);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        acc(1'b0, a, $urandom(), 4'($urandom()), e, "read");
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] wd,
                      input logic [3:0] be, input logic h);
        acc(1'b1, a, wd, be, {h, 32'h0}, "write");
    endtask
    task automatic en(input logic p, input logic s);
        chk("enables", {31'h0, p, s}, {31'h0, pm_en, aspm_en});
    endtask
    task automatic ld(input logic e, input logic s, input logic [2:0] v,
                      input logic sv);
        @(posedge clock);
        #1;
        cfg_req = 1'b0;
        eeprom_load = e;
        sideband_load = s;
        ee = v;
        sb_aspm = sv;
        // eeprom wins when both strobes meet
        if (e) cap_w = {27'h0, v[2], v[1], 1'b0, v[0], 1'b0};
        else if (s) cap_w[3] = sv;
        step();
    endtask
    task automatic reboot(input logic ds);
        @(posedge clock);
        #1;
        rst_n = 1'b0;
        downstream_strap = ds;
        repeat (20) @(posedge clock);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        cap_w = 32'h12;
    endtask
    initial begin
        void'($urandom(32'h2c4b));
        reboot(1'b0);
        en(1'b0, 1'b0);
        rd(12'h240, {1'b1, 32'h2601001e});
        rd(12'h244, {1'b1, 32'h12});
        rd(12'h248, {1'b1, 32'h0});
        rd(12'h24c, {1'b1, 32'h0});
        rd(12'h250, 33'h0);
        rd(12'h254, 33'h0);
        tend("upstream_map");
        wr(12'h248, 32'hffffffff, 4'h1, 1'b1);
        rd(12'h248, {1'b1, 32'ha});
        step();
        en(1'b1, 1'b1);
        wr(12'h248, 32'h0, 4'he, 1'b1);
        rd(12'h248, {1'b1, 32'ha});
        for (int i = 0; i < 8; i++) begin
            d = $urandom();
            wr(12'h248, d, 4'h1, 1'b1);
            rd(12'h248, {1'b1, d & 32'ha});
            step();
            en(d[1], d[3]);
        end
        wr(12'h24c, 32'hffffffff, 4'hf, 1'b1);
        rd(12'h24c, {1'b1, 32'h0});
        wr(12'h244, 32'h0, 4'hf, 1'b1);
        rd(12'h244, {1'b1, 32'h12});
        wr(12'h240, 32'h0, 4'hf, 1'b1);
        rd(12'h240, {1'b1, 32'h2601001e});
        wr(12'h258, 32'h0, 4'hf, 1'b0);
        tend("control_writes");
        for (int i = 0; i < 8; i++) begin
            d = $urandom();
            ld(d[0], d[1], d[4:2], d[5]);
            rd(12'h244, {1'b1, cap_w});
        end
        ld(1'b1, 1'b1, 3'h3, 1'b0);
        rd(12'h244, {1'b1, cap_w});
        ld(1'b0, 1'b1, 3'h0, 1'b1);
        rd(12'h244, {1'b1, cap_w});
        tend("default_loads");
        wr(12'h248, 32'ha, 4'h1, 1'b1);
        step();
        @(posedge clock);
        #1;
        clk_en = 1'b0;
        cfg_req = 1'b1;
        cfg_write = 1'b1;
        cfg_addr = 12'h248;
        cfg_be = 4'h1;
        cfg_wdata = 32'h0;
        eeprom_load = 1'b1;
        ee = 3'h0;
        repeat (2) @(posedge clock);
        #1;
        cfg_req = 1'b0;
        eeprom_load = 1'b0;
        clk_en = 1'b1;
        en(1'b1, 1'b1);
        rd(12'h244, {1'b1, cap_w});
        tend("clock_enable");
        reboot(1'b1);
        en(1'b0, 1'b0);
        rd(12'h240, {1'b1, 32'h2501001e});
        rd(12'h250, {1'b1, 32'h0001001d});
        rd(12'h254, {1'b1, 32'h1});
        wr(12'h254, 32'hffffffff, 4'hf, 1'b1);
        rd(12'h254, {1'b1, 32'h1});
        rd(12'h244, {1'b1, 32'h12});
        rd(12'h258, 33'h0);
        tend("downstream_map");
        complete_run();
    end
endmodule
